// file: core/pwm_obj_pkg.sv
// package for the dual pulse-width object interface
// assumes a single module clock and a power-on reset
package pwm_obj_pkg;
  // register numbers of the internal module bus, channel one and two
  localparam logic [6:0] CH1_PERIOD_DURATION = 7'h60;
  localparam logic [6:0] CH1_DUTY_CYCLE = 7'h61;
  localparam logic [6:0] CH1_LOAD_PREPARE_VALUE = 7'h64;
  localparam logic [6:0] CH1_LATCHED_COUNT = 7'h66;
  localparam logic [6:0] CH2_PERIOD_DURATION = 7'h70;
  localparam logic [6:0] CH2_DUTY_CYCLE = 7'h71;
  localparam logic [6:0] CH2_LOAD_PREPARE_VALUE = 7'h74;
  localparam logic [6:0] CH2_LATCHED_COUNT = 7'h76;
  // object selectors for the per-channel objects
  localparam logic [2:0] OBJ_CONFIG = 3'h0;
  localparam logic [2:0] OBJ_STATUS = 3'h1;
  localparam logic [2:0] OBJ_FLAGS = 3'h2;
  localparam logic [2:0] OBJ_DIAG = 3'h3;
  localparam logic [2:0] OBJ_CONTROL = 3'h4;
  localparam logic [2:0] OBJ_REGISTER = 3'h5;
  // configuration word layout and defaults
  localparam int CFG_DIAG_EN_BIT = 7;
  localparam int CFG_AUX_ADDR_LSB = 24;
  localparam logic [5:0] CFG_OUT_MODE_RST = 6'h3F;
  localparam logic [7:0] CFG_BYTE1_RST = 8'h00;
  localparam logic [6:0] CFG_AUX_CH1_RST = 7'h60;
  localparam logic [6:0] CFG_AUX_CH2_RST = 7'h70;
  // control word bit positions
  localparam int CTL_GLOBAL_OFF = 0;
  localparam int CTL_START_STOP = 1;
  localparam int CTL_HOLD_ERRORS = 2;
  localparam int CTL_SPECIAL_OFF = 4;
  localparam int CTL_SOFT_RETRIGGER = 5;
  localparam int CTL_SINGLE_SHOT = 6;
  localparam int CTL_FORCE_DIGITAL = 8;
  localparam int CTL_FORCE_PULSE = 9;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h0377;
  // flag and diagnostic bit positions
  localparam int FLG_RETRIGGER = 0;
  localparam int FLG_ZERO_CROSS = 1;
  localparam int FLG_SPECIAL = 2;
  localparam int FLG_OUT_ERROR = 3;
  localparam int DIAG_HW = 7;
  localparam int DIAG_PARAM = 6;
  localparam int DIAG_PULSE = 1;
  localparam int DIAG_DIGITAL = 0;
  // accepted range of the output mode field
  localparam logic [5:0] MODE_MAX_VALID = 6'h3F;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // output sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } run_state_t;
endpackage

// file: core/dual_pwm_object_interface.sv
// dual pulse-width output channels with object access for the gateway
// assumes requests are synchronous to clk_in; one access per cycle
`timescale 1ns/1ps
module dual_pwm_object_interface
  import pwm_obj_pkg::*;
#(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // object access from the gateway
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic ch_sel_in,
  input wire logic [2:0] obj_in,
  input wire logic [6:0] reg_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  output logic ack_out,
  output logic err_out,
  // cyclic process data for the period duration
  input wire logic [NCH-1:0] pd_period_we_in,
  input wire logic [31:0] pd_period_in,
  // stored configuration restored after node reset
  input wire logic [NCH-1:0] cfg_restore_in,
  input wire logic [31:0] cfg_store_in,
  // external event sources
  input wire logic [NCH-1:0] load_event_in,
  input wire logic [NCH-1:0] latch_event_in,
  input wire logic [NCH-1:0] special_event_in,
  input wire logic [NCH-1:0] hw_fault_in,
  input wire logic [NCH-1:0] pulse_fault_in,
  input wire logic [NCH-1:0] digital_fault_in,
  // channel outputs
  output logic [NCH-1:0] pulse_out,
  output logic [NCH-1:0] digital_out,
  output logic [NCH-1:0] compare_status_output
);
  import pwm_obj_pkg::*;

  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic ack_q;
  logic err_q;
  logic [31:0] ch_rd [NCH];
  logic [NCH-1:0] ch_err;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      logic [31:0] cfg_q;
      logic [15:0] ctl_q;
      logic [31:0] period_q;
      logic [31:0] duty_q;
      logic [31:0] loadv_q;
      logic [31:0] latch_q;
      logic [31:0] cnt_q;
      logic [3:0] flags_q;
      logic [3:0] diag_q;
      logic pulse_q;
      logic digital_q;
      logic retrig_q;
      run_state_t st_q;
      logic sel;
      logic acc_wr;
      logic acc_rd;
      logic [6:0] base;
      logic [6:0] reg_idx;
      logic gen_en;
      logic special_en;
      logic zero_cross;
      logic out_err;
      logic par_err;
      logic hold;
      logic [3:0] fl_set;
      logic [3:0] dg_set;
      logic [7:0] status;

      // named control bits of the host word
      logic function_global_off;
      logic output_start_stop;
      logic hold_error_messages;
      logic special_function_off;
      logic soft_latch_retrigger_request;
      logic single_shot_select;
      logic force_digital_output;
      logic force_pulse_output;

      // named status, flag and diagnostic bits
      logic general_enabled_status;
      logic output_running_status;
      logic special_function_enabled_status;
      logic errors_held_status;
      logic soft_latch_retrigger_done_flag;
      logic zero_crossing_flag;
      logic special_event_flag;
      logic output_error_flag;
      logic hardware_fault_diag;
      logic parameter_fault_diag;
      logic pulse_output_fault_diag;
      logic digital_output_fault_diag;
      logic [1:0] status_output_mode;

      // request decode for this channel
      assign sel = req_in && (ch_sel_in == 1'(g));
      assign acc_wr = sel && wr_in;
      assign acc_rd = sel && !wr_in;
      assign base = (g == 0) ? CH1_PERIOD_DURATION : CH2_PERIOD_DURATION;
      assign reg_idx = reg_in - base;

      // control word fields
      assign function_global_off = ctl_q[CTL_GLOBAL_OFF];
      assign output_start_stop = ctl_q[CTL_START_STOP];
      assign hold_error_messages = ctl_q[CTL_HOLD_ERRORS];
      assign special_function_off = ctl_q[CTL_SPECIAL_OFF];
      assign soft_latch_retrigger_request = ctl_q[CTL_SOFT_RETRIGGER];
      assign single_shot_select = ctl_q[CTL_SINGLE_SHOT];
      assign force_digital_output = ctl_q[CTL_FORCE_DIGITAL];
      assign force_pulse_output = ctl_q[CTL_FORCE_PULSE];
      assign gen_en = !function_global_off;
      assign special_en = !special_function_off;
      assign hold = hold_error_messages;

      // event sources and fault terms
      assign zero_cross = (st_q == ST_RUN) && (cnt_q == WORD_RST);
      assign out_err = pulse_fault_in[g] || digital_fault_in[g];
      assign par_err = (cfg_q[5:0] > MODE_MAX_VALID) || (period_q[31]) || duty_q[31];
      assign fl_set = {out_err, special_event_in[g] && special_en,
                       zero_cross, retrig_q};
      assign dg_set = {hw_fault_in[g], par_err, pulse_fault_in[g],
                       digital_fault_in[g]};

      // status byte fields
      assign general_enabled_status = gen_en;
      assign output_running_status = (st_q == ST_RUN);
      assign special_function_enabled_status = special_en && gen_en;
      assign errors_held_status = hold;
      // status byte, bits 7..6 read zero
      assign status = {2'b00, compare_status_output[g], digital_q, errors_held_status,
                       special_function_enabled_status, output_running_status,
                       general_enabled_status};

      // latched flag and diagnostic fields
      assign soft_latch_retrigger_done_flag = flags_q[FLG_RETRIGGER];
      assign zero_crossing_flag = flags_q[FLG_ZERO_CROSS];
      assign special_event_flag = flags_q[FLG_SPECIAL];
      assign output_error_flag = flags_q[FLG_OUT_ERROR];
      assign hardware_fault_diag = diag_q[3];
      assign parameter_fault_diag = diag_q[2];
      assign pulse_output_fault_diag = diag_q[1];
      assign digital_output_fault_diag = diag_q[0];
      assign status_output_mode = cfg_q[15:14];

      // configuration word: reset default, restore, service write
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          cfg_q <= {1'b0, (g == 0) ? CFG_AUX_CH1_RST : CFG_AUX_CH2_RST, 8'h00,
                    CFG_BYTE1_RST, 2'b00, CFG_OUT_MODE_RST};
        end else if (cfg_restore_in[g]) begin
          cfg_q <= {1'b0, cfg_store_in[30:0]};
        end else if (acc_wr && obj_in == OBJ_CONFIG) begin
          cfg_q <= {1'b0, wdata_in[30:0]};
        end
      end

      // control word written by the host
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ctl_q <= 16'h0000;
        end else if (acc_wr && obj_in == OBJ_CONTROL) begin
          ctl_q <= wdata_in[15:0] & CTL_WRITE_MASK;
        end
      end

      // rising edge of the retrigger request arms a one-cycle capture
      logic sw_lr_prev_q;
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          sw_lr_prev_q <= 1'b0;
          retrig_q <= 1'b0;
        end else begin
          sw_lr_prev_q <= soft_latch_retrigger_request;
          retrig_q <= soft_latch_retrigger_request && !sw_lr_prev_q;
        end
      end

      // value registers: period, duty, load value
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          period_q <= WORD_RST;
          duty_q <= WORD_RST;
          loadv_q <= WORD_RST;
        end else begin
          if (acc_wr && obj_in == OBJ_REGISTER) begin
            case (reg_idx)
              7'h00: period_q <= wdata_in;
              7'h01: duty_q <= wdata_in;
              7'h04: loadv_q <= wdata_in;
              default: ;
            endcase
          end else if (pd_period_we_in[g]) begin
            period_q <= pd_period_in;
          end
        end
      end

      // output counter sequencer
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          st_q <= ST_IDLE;
          cnt_q <= WORD_RST;
        end else if (load_event_in[g]) begin
          cnt_q <= loadv_q;
        end else begin
          case (st_q)
            ST_IDLE: begin
              if (gen_en && output_start_stop) begin
                st_q <= ST_RUN;
                cnt_q <= period_q;
              end
            end
            ST_RUN: begin
              if (!gen_en || !output_start_stop) begin
                st_q <= ST_IDLE;
              end else if (cnt_q == WORD_RST) begin
                cnt_q <= period_q;
                st_q <= single_shot_select ? ST_DONE : ST_RUN;
              end else begin
                cnt_q <= cnt_q - 32'h0000_0001;
              end
            end
            ST_DONE: begin
              if (!output_start_stop) st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end

      // latch captures count on event or soft retrigger
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          latch_q <= WORD_RST;
        end else if (latch_event_in[g] || retrig_q) begin
          latch_q <= cnt_q;
        end
      end

      // pulse and digital outputs; forced bits override
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          pulse_q <= 1'b0;
          digital_q <= 1'b0;
        end else begin
          pulse_q <= force_pulse_output ||
                     ((st_q == ST_RUN) && ($signed(cnt_q) < $signed(duty_q)));
          digital_q <= force_digital_output;
        end
      end

      // sticky flags: set wins over clear-on-read; hold blocks clearing
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          flags_q <= 4'h0;
          diag_q <= 4'h0;
        end else begin
          flags_q <= ((acc_rd && obj_in == OBJ_FLAGS && !hold) ? 4'h0 : flags_q)
                     | fl_set;
          diag_q <= ((acc_rd && obj_in == OBJ_DIAG && !hold) ? 4'h0 : diag_q)
                    | (cfg_q[CFG_DIAG_EN_BIT] ? dg_set : 4'h0);
        end
      end

      // read mux for this channel
      always_comb begin
        ch_rd[g] = WORD_RST;
        ch_err[g] = 1'b0;
        case (obj_in)
          OBJ_CONFIG: ch_rd[g] = cfg_q;
          OBJ_STATUS: ch_rd[g] = {24'h0, status};
          OBJ_FLAGS: ch_rd[g] = {28'h0, output_error_flag, special_event_flag,
                                 zero_crossing_flag, soft_latch_retrigger_done_flag};
          OBJ_DIAG: ch_rd[g] = {24'h0, hardware_fault_diag, parameter_fault_diag, 4'h0,
                                pulse_output_fault_diag,
                                digital_output_fault_diag};
          OBJ_CONTROL: ch_rd[g] = {16'h0, ctl_q};
          OBJ_REGISTER: begin
            case (reg_idx)
              7'h00: ch_rd[g] = period_q;
              7'h01: ch_rd[g] = duty_q;
              7'h04: ch_rd[g] = loadv_q;
              7'h06: ch_rd[g] = latch_q;
              default: ch_err[g] = 1'b1;
            endcase
            if (wr_in && reg_idx == 7'h06) ch_err[g] = 1'b1;
          end
          default: ch_err[g] = 1'b1;
        endcase
        if (wr_in && (obj_in == OBJ_STATUS || obj_in == OBJ_FLAGS
            || obj_in == OBJ_DIAG)) ch_err[g] = 1'b1;
      end

      assign pulse_out[g] = pulse_q;
      assign digital_out[g] = digital_q;
      assign compare_status_output[g] = (status_output_mode == 2'b00) ?
                                        pulse_q : cfg_q[14];
    end
  endgenerate

  // registered answer, one cycle after the request
  always_comb begin
    rd_d = ch_rd[ch_sel_in];
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= WORD_RST;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req_in;
      err_q <= req_in && ch_err[ch_sel_in];
      if (req_in && !wr_in) rdata_q <= rd_d;
    end
  end

  assign rdata_out = rdata_q;
  assign ack_out = ack_q;
  assign err_out = err_q;
endmodule

// file: verification/dual_pwm_asserts.sv
// checker for the object access of the two pulse channels
// assumes binding to the top module, one clock domain
`timescale 1ns/1ps
module dual_pwm_checker
  import pwm_obj_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // object access
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [2:0] obj_in,
  input wire logic [6:0] reg_in,
  input wire logic [31:0] rdata_out,
  input wire logic ack_out,
  input wire logic err_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // answer timing
  a_ack_after_req: assert property (req_in |=> ack_out) else $error("no ack");
  a_ack_needs_req: assert property (ack_out |-> $past(req_in)) else $error("stray ack");
  // read-only objects refuse writes
  a_status_write_refused: assert property (req_in && wr_in && obj_in == OBJ_STATUS |=> err_out)
    else $error("status write taken");
  a_flags_write_refused: assert property (req_in && wr_in && obj_in == OBJ_FLAGS |=> err_out)
    else $error("flags write taken");
  a_diag_write_refused: assert property (req_in && wr_in && obj_in == OBJ_DIAG |=> err_out)
    else $error("diag write taken");
  a_latch_write_refused: assert property (req_in && wr_in && obj_in == OBJ_REGISTER &&
    (reg_in == CH1_LATCHED_COUNT || reg_in == CH2_LATCHED_COUNT) |=> err_out)
    else $error("latch write taken");
  // unused bits read as zero
  a_status_read_clean: assert property (req_in && !wr_in && obj_in == OBJ_STATUS |=>
    !err_out && rdata_out[7:6] == 2'b00) else $error("status read bad");
  a_config_msb_zero: assert property (req_in && !wr_in && obj_in == OBJ_CONFIG |=>
    !err_out && !rdata_out[31]) else $error("config read bad");
  a_flags_read_clean: assert property (req_in && !wr_in && obj_in == OBJ_FLAGS |=>
    !err_out && rdata_out[7:4] == 4'h0) else $error("flags read bad");
  a_diag_read_clean: assert property (req_in && !wr_in && obj_in == OBJ_DIAG |=>
    !err_out && rdata_out[5:2] == 4'h0) else $error("diag read bad");
endmodule
bind dual_pwm_object_interface dual_pwm_checker chk_u (.clk_in(clk_in), .rstn_in(rstn_in),
  .req_in(req_in), .wr_in(wr_in), .obj_in(obj_in), .reg_in(reg_in), .rdata_out(rdata_out),
  .ack_out(ack_out), .err_out(err_out));

// file: verification/gateway_model.sv
// gateway side model issuing one service access at a time
// assumes the bench calls acc from a single process
`timescale 1ns/1ps
module gateway_model (
  // clock and answer
  input wire logic clk_in,
  input wire logic ack_out,
  input wire logic err_out,
  input wire logic [31:0] rdata_out,
  // request lines
  output logic req_in,
  output logic wr_in,
  output logic ch_sel_in,
  output logic [2:0] obj_in,
  output logic [6:0] reg_in,
  output logic [31:0] wdata_in
);
  // idle lines at time zero
  initial begin
    {req_in, wr_in, ch_sel_in, obj_in, reg_in} = '0;
    wdata_in = 32'h0000_0000;
  end
  // one access; e is unknown when no answer came
  task automatic acc(input logic w, input logic c, input logic [2:0] o, input logic [6:0] r,
                     input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_in);
    req_in <= 1'b1;
    wr_in <= w;
    ch_sel_in <= c;
    obj_in <= o;
    reg_in <= r;
    wdata_in <= d;
    @(posedge clk_in);
    req_in <= 1'b0;
    wdata_in <= ~d; // released data never shows the last value
    #1;
    q = rdata_out;
    e = ack_out ? err_out : 1'bx;
  endtask
endmodule

// file: verification/dual_pwm_object_interface_bench.sv
// self-checking bench for the dual pulse-width object interface
// assumes the gateway model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dual_pwm_object_interface_bench;
  import pwm_obj_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic req_in, wr_in, ch_sel_in, ack_out, err_out, e;
  logic [2:0] obj_in;
  logic [6:0] reg_in;
  logic [31:0] wdata_in, rdata_out, q;
  logic [31:0] pd_period_in = 32'h0, cfg_store_in = 32'h0;
  logic [1:0] pd_period_we_in = 2'b00, cfg_restore_in = 2'b00;
  logic [1:0] pulse_out, digital_out, cso;
  logic [11:0] evt = 12'h000;
  logic [6:0] regs [6] = '{CH1_PERIOD_DURATION, CH1_DUTY_CYCLE, CH1_LOAD_PREPARE_VALUE,
    CH2_PERIOD_DURATION, CH2_DUTY_CYCLE, CH2_LOAD_PREPARE_VALUE};
  int error_cnt = 0;
  int comparisons = 0;
  int c;
  always #50 clk_in = ~clk_in;
  gateway_model gw_u (.clk_in(clk_in), .ack_out(ack_out), .err_out(err_out),
    .rdata_out(rdata_out), .req_in(req_in), .wr_in(wr_in), .ch_sel_in(ch_sel_in),
    .obj_in(obj_in), .reg_in(reg_in), .wdata_in(wdata_in));
  dual_pwm_object_interface dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req_in),
    .wr_in(wr_in), .ch_sel_in(ch_sel_in), .obj_in(obj_in), .reg_in(reg_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .ack_out(ack_out), .err_out(err_out),
    .pd_period_we_in(pd_period_we_in), .pd_period_in(pd_period_in),
    .cfg_restore_in(cfg_restore_in), .cfg_store_in(cfg_store_in),
    .load_event_in(evt[1:0]), .latch_event_in(evt[3:2]), .special_event_in(evt[5:4]),
    .hw_fault_in(evt[7:6]), .pulse_fault_in(evt[9:8]), .digital_fault_in(evt[11:10]),
    .pulse_out(pulse_out), .digital_out(digital_out), .compare_status_output(cso));
  // access checked for answer code and, on reads, data d
  task automatic xs(input string n, input logic w, input logic ch, input logic [2:0] o,
                    input logic [6:0] r, input logic [31:0] d, input logic ee);
    gw_u.acc(w, ch, o, r, d, q, e);
    if (o inside {OBJ_STATUS, OBJ_FLAGS, OBJ_DIAG}) q = q & 32'h0000_00FF;
    `CHK(n, ee, e)
    if (!w && !ee) `CHK(n, d, q)
  endtask
  // one-cycle pulse on event k of channel ch
  task automatic ev(input int k, input int ch);
    @(posedge clk_in) evt[2*k+ch] <= 1'b1;
    @(posedge clk_in) evt[2*k+ch] <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    #200_000;
    error_cnt++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    xs("cfg1", 0, 0, OBJ_CONFIG, 7'h00, 32'h6000_003F, 0);
    xs("cfg2", 0, 1, OBJ_CONFIG, 7'h00, 32'h7000_003F, 0);
    xs("cfgw", 1, 0, OBJ_CONFIG, 7'h00, 32'h5A00_C0A5, 0);
    xs("cfgr", 0, 0, OBJ_CONFIG, 7'h00, 32'h5A00_C0A5, 0);
    for (c = 0; c < 6; c++) xs("vw", 1, c > 2, OBJ_REGISTER, regs[c], 32'h0000_0A00 + c, 0);
    for (c = 0; c < 6; c++) xs("vr", 0, c > 2, OBJ_REGISTER, regs[c], 32'h0000_0A00 + c, 0);
    for (c = 1; c < 4; c++) xs("ro", 1, 0, c[2:0], 7'h00, 32'hFF, 1);
    xs("latw", 1, 1, OBJ_REGISTER, CH2_LATCHED_COUNT, 32'h1, 1);
    xs("badr", 0, 0, OBJ_REGISTER, 7'h62, 32'h0, 1);
    // process data period write on channel two
    @(posedge clk_in) pd_period_in <= 32'h0000_1234;
    pd_period_we_in <= 2'b10;
    @(posedge clk_in) pd_period_we_in <= 2'b00;
    xs("pdp", 0, 1, OBJ_REGISTER, CH2_PERIOD_DURATION, 32'h0000_1234, 0);
    // stored configuration restored on channel two
    @(posedge clk_in) cfg_store_in <= 32'h7000_0021;
    cfg_restore_in <= 2'b10;
    @(posedge clk_in) cfg_restore_in <= 2'b00;
    xs("rest", 0, 1, OBJ_CONFIG, 7'h00, 32'h7000_0021, 0);
    // load value reaches the count only on its event
    ev(1, 0);
    gw_u.acc(0, 0, OBJ_REGISTER, CH1_LATCHED_COUNT, 32'h0, q, e);
    `CHK("nold", 1'b0, q === 32'h0000_0A02)
    ev(0, 0);
    ev(1, 0);
    xs("ld", 0, 0, OBJ_REGISTER, CH1_LATCHED_COUNT, 32'h0000_0A02, 0);
    // flags, clear on read and hold
    gw_u.acc(0, 0, OBJ_FLAGS, 7'h00, 32'h0, q, e);
    ev(2, 0);
    xs("flg", 0, 0, OBJ_FLAGS, 7'h00, 32'h04, 0);
    xs("flgc", 0, 0, OBJ_FLAGS, 7'h00, 32'h00, 0);
    xs("hold", 1, 0, OBJ_CONTROL, 7'h00, 32'h0000_0004, 0);
    ev(2, 0);
    xs("flgh", 0, 0, OBJ_FLAGS, 7'h00, 32'h04, 0);
    xs("flgk", 0, 0, OBJ_FLAGS, 7'h00, 32'h04, 0);
    gw_u.acc(0, 0, OBJ_STATUS, 7'h00, 32'h0, q, e);
    `CHK("held", 1'b1, q[3])
    xs("rtg", 1, 0, OBJ_CONTROL, 7'h00, 32'h0000_0020, 0);
    xs("ctl", 0, 0, OBJ_CONTROL, 7'h00, 32'h0000_0020, 0);
    xs("flgr", 0, 0, OBJ_FLAGS, 7'h00, 32'h05, 0);
    xs("flg0", 0, 0, OBJ_FLAGS, 7'h00, 32'h00, 0);
    xs("mskw", 1, 0, OBJ_CONTROL, 7'h00, 32'hFFFF_FC88, 0);
    xs("mskr", 0, 0, OBJ_CONTROL, 7'h00, 32'h0000_0000, 0);
    // diagnostics, enabled on channel one: hardware, pulse, digital faults
    ev(3, 0);
    xs("dg", 0, 0, OBJ_DIAG, 7'h00, 32'h80, 0);
    ev(4, 0);
    ev(5, 0);
    xs("dgo", 0, 0, OBJ_DIAG, 7'h00, 32'h03, 0);
    xs("dgc", 0, 0, OBJ_DIAG, 7'h00, 32'h00, 0);
    // forced outputs on channel two only
    xs("frc", 1, 1, OBJ_CONTROL, 7'h00, 32'h0000_0300, 0);
    repeat (3) @(posedge clk_in);
    `CHK("pout", 1'b1, pulse_out[1])
    `CHK("dout", 1'b1, digital_out[1])
    `CHK("iso", 1'b0, digital_out[0])
    `CHK("cso", 1'b1, cso[1])
    gw_u.acc(0, 1, OBJ_STATUS, 7'h00, 32'h0, q, e);
    `CHK("dlev", 1'b1, q[4])
    summarize();
  end
endmodule
